/* File: rtl/ctw_ctrl.sv */
// mode, wake and indication logic of a fault tolerant bus transceiver
`include "ctw_cfg.svh"
module ctw_ctrl
  import ctw_pkg::*;
(
  // clock and power-on reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // protocol controller side
  input  wire logic txData,
  input  wire logic txValid,
  output logic      txReady,
  output logic      rxData,
  input  wire logic standby_n,
  input  wire logic enable,
  output logic      errWake_n,
  // supply monitor
  input  wire logic logicSupplyOk,
  // bus comparators and drivers
  input  wire logic busHighDom,
  input  wire logic busLowDom,
  input  wire logic diffDom,
  output logic      highDrive,
  output logic      lowDrive,
  output logic      highDriveEn,
  output logic      lowDriveEn,
  // local wake and regulator inhibit
  input  wire logic localWake,
  output logic      regulator_inhibit_out,
  output logic      inhibitEn,
  output ctw_mode_t mode
);
  localparam logic [11:0] WAKE_CYC  = 12'(`CTW_WAKE_CYC);
  localparam logic [11:0] BUSW_CYC  = 12'(`CTW_BUS_WAKE_CYC);
  localparam logic [7:0]  HOLD_CYC  = 8'(`CTW_SLEEP_HOLD_CYC);
  localparam logic [15:0] FAULT_CYC = 16'(`CTW_FAULT_CYC);
  localparam logic [3:0]  PDIFF     = 4'(`CTW_PULSE_DIFF);

  //////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [1:0] stbSync_q, enSync_q, wakeSync_q, supSync_q;
  logic [1:0] hiSync_q, loSync_q, dfSync_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stbSync_q  <= 2'h3; // idle as power-on standby, no false sleep
      enSync_q   <= 2'h0;
      wakeSync_q <= 2'h0;
      supSync_q  <= 2'h3; // supply taken as good until sampled
      hiSync_q   <= 2'h0;
      loSync_q   <= 2'h0;
      dfSync_q   <= 2'h0;
    end else begin
      stbSync_q  <= {stbSync_q[0], standby_n};
      enSync_q   <= {enSync_q[0], enable};
      wakeSync_q <= {wakeSync_q[0], localWake};
      supSync_q  <= {supSync_q[0], logicSupplyOk};
      hiSync_q   <= {hiSync_q[0], busHighDom};
      loSync_q   <= {loSync_q[0], busLowDom};
      dfSync_q   <= {dfSync_q[0], diffDom};
    end
  end
  logic stbIn, enIn, wakeIn, hiDom, loDom, dfDom;
  // supply below threshold forces both controls low
  assign stbIn = stbSync_q[1] && supSync_q[1];
  assign enIn  = enSync_q[1] && supSync_q[1];
  assign wakeIn = wakeSync_q[1];
  assign hiDom  = hiSync_q[1];
  assign loDom  = loSync_q[1];
  assign dfDom  = dfSync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // mode decode; sleep only after go-to-sleep held long enough
  ctw_mode_t mode_d, mode_q;
  logic [7:0] holdCnt_q;
  logic       wakeEvt;
  always_comb begin
    mode_d = mode_q;
    case ({stbIn, enIn})
      2'b11: mode_d = CTW_NORMAL;
      2'b10: mode_d = CTW_PONSTBY;
      2'b01: mode_d = (holdCnt_q >= HOLD_CYC) ? CTW_SLEEP : CTW_GOSLEEP;
      default: begin
        if (mode_q != CTW_SLEEP || wakeEvt) begin
          mode_d = CTW_GOSLEEP;
        end
        if (mode_q == CTW_GOSLEEP && holdCnt_q >= HOLD_CYC) begin
          mode_d = CTW_SLEEP;
        end
      end
    endcase
    if (mode_q == CTW_SLEEP && !stbIn && !wakeEvt) begin
      mode_d = CTW_SLEEP;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      mode_q <= CTW_PONSTBY;
    end else begin
      mode_q <= mode_d;
    end
  end
  // go-to-sleep hold counter
  always_ff @(posedge clock) begin
    if (sys_rst || mode_q != CTW_GOSLEEP) begin
      holdCnt_q <= 8'h0;
    end else if (holdCnt_q < HOLD_CYC && !stbIn && enIn) begin
      holdCnt_q <= holdCnt_q + 8'h1;
    end
  end
  assign mode = mode_q;

  //////////////////////////////////////////////////////////////////////////
  // local wake pulse filter, both polarities
  logic        wakeRef_q;
  logic [11:0] wakeCnt_q;
  logic        localWakeEvt;
  logic [1:0]  seedCnt_q;
  assign localWakeEvt = (wakeIn != wakeRef_q) && (wakeCnt_q >= WAKE_CYC);
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wakeRef_q <= 1'b0;
      wakeCnt_q <= 12'h0;
    end else if (wakeIn == wakeRef_q || seedCnt_q != 2'h3) begin
      wakeRef_q <= wakeIn; // follow the pin until it has settled
      wakeCnt_q <= 12'h0;
    end else if (localWakeEvt) begin
      wakeRef_q <= wakeIn;
      wakeCnt_q <= 12'h0;
    end else begin
      wakeCnt_q <= wakeCnt_q + 12'h1;
    end
  end
  // seed the wake reference once the synchroniser holds the pin level
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      seedCnt_q <= 2'h0;
    end else if (seedCnt_q != 2'h3) begin
      seedCnt_q <= seedCnt_q + 2'h1;
    end
  end

  // bus dominant wake while either control is low
  logic [11:0] busCnt_q;
  logic        busWakeEvt;
  assign busWakeEvt = (busCnt_q >= BUSW_CYC);
  always_ff @(posedge clock) begin
    if (sys_rst || !dfDom || (stbIn && enIn) || busWakeEvt) begin
      busCnt_q <= 12'h0;
    end else begin
      busCnt_q <= busCnt_q + 12'h1;
    end
  end
  assign wakeEvt = localWakeEvt || busWakeEvt;

  //////////////////////////////////////////////////////////////////////////
  // inhibit output: high after power-on, floats in sleep
  logic inhFloat_q, wakeFlag_q, ponFlag_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      inhFloat_q <= 1'b0;
    end else if (wakeEvt) begin
      inhFloat_q <= 1'b0;
    end else if (mode_d == CTW_SLEEP) begin
      inhFloat_q <= 1'b1;
    end
  end
  assign regulator_inhibit_out = 1'b1;
  assign inhibitEn = !inhFloat_q;

  // power-on and wake flags; wake set wins over clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ponFlag_q  <= 1'b1;
      wakeFlag_q <= 1'b0;
    end else begin
      if (mode_q == CTW_NORMAL) begin
        ponFlag_q <= 1'b0;
      end
      if (wakeEvt) begin
        wakeFlag_q <= 1'b1;
      end else if (mode_q == CTW_NORMAL) begin
        wakeFlag_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // failure detector: pulse count difference and dominant timeout
  logic       hiPrev_q, loPrev_q;
  logic [3:0] hiCnt_q, loCnt_q;
  logic       wireFail_q, shortFail_q;
  logic [15:0] domCnt_q;
  logic       hiEdge, loEdge;
  assign hiEdge = hiDom && !hiPrev_q;
  assign loEdge = loDom && !loPrev_q;
  always_ff @(posedge clock) begin
    if (sys_rst || mode_q != CTW_NORMAL) begin
      hiPrev_q   <= 1'b0;
      loPrev_q   <= 1'b0;
      hiCnt_q    <= 4'h0;
      loCnt_q    <= 4'h0;
      wireFail_q <= 1'b0;
    end else begin
      hiPrev_q <= hiDom;
      loPrev_q <= loDom;
      if (hiEdge && loEdge) begin
        hiCnt_q <= 4'h0; // both lines pulse together: healthy
        loCnt_q <= 4'h0;
        wireFail_q <= 1'b0;
      end else if (hiEdge && hiCnt_q < PDIFF) begin
        hiCnt_q <= hiCnt_q + 4'h1;
        loCnt_q <= 4'h0;
      end else if (loEdge && loCnt_q < PDIFF) begin
        loCnt_q <= loCnt_q + 4'h1;
        hiCnt_q <= 4'h0;
      end
      if (hiCnt_q == PDIFF || loCnt_q == PDIFF) begin
        wireFail_q <= 1'b1;
      end
    end
  end
  // permanent dominant on a line means a short: go single wire
  always_ff @(posedge clock) begin
    if (sys_rst || mode_q != CTW_NORMAL) begin
      domCnt_q    <= 16'h0;
      shortFail_q <= 1'b0;
    end else if (dfDom != (hiDom && loDom) || (hiDom ^ loDom)) begin
      if (domCnt_q < FAULT_CYC) begin
        domCnt_q <= domCnt_q + 16'h1;
      end else begin
        shortFail_q <= 1'b1;
      end
    end else begin
      domCnt_q    <= 16'h0;
      shortFail_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit path through the fifo, one bit per cycle
  logic txFifoValid, txFifoData, txBit_q;
  ctw_fifo #(.WIDTH(1), .DEPTH(`CTW_FIFO_DEPTH)) u_txFifo (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   (txData),
    .outValid (txFifoValid),
    .outReady (mode_q == CTW_NORMAL),
    .outData  (txFifoData)
  );
  always_ff @(posedge clock) begin
    if (sys_rst || mode_q != CTW_NORMAL) begin
      txBit_q <= 1'b1; // recessive
    end else if (txFifoValid) begin
      txBit_q <= txFifoData;
    end
  end
  // drivers: differential, or one wire when shorted
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      highDrive   <= 1'b0;
      lowDrive    <= 1'b0;
      highDriveEn <= 1'b0;
      lowDriveEn  <= 1'b0;
    end else begin
      highDrive   <= !txBit_q;
      lowDrive    <= !txBit_q;
      highDriveEn <= (mode_q == CTW_NORMAL) && !(shortFail_q && hiDom);
      lowDriveEn  <= (mode_q == CTW_NORMAL) && !(shortFail_q && !hiDom);
    end
  end
  // receive: differential comparator or surviving wire
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rxData <= 1'b1;
    end else if (shortFail_q) begin
      rxData <= hiDom ? !loDom : !hiDom;
    end else begin
      rxData <= !dfDom;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // error/wake indication
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      errWake_n <= 1'b0;
    end else begin
      case (mode_d)
        CTW_NORMAL:  errWake_n <= !(wireFail_q || shortFail_q);
        CTW_PONSTBY: errWake_n <= !ponFlag_q;
        default:     errWake_n <= !wakeFlag_q;
      endcase
    end
  end

  // power-on flag clears only in normal mode
  chk_pon_clear: assert property (@(posedge clock)
    disable iff (sys_rst) ponFlag_q && mode_q != CTW_NORMAL |=> ponFlag_q)
    else $error("power-on flag cleared outside normal mode");
  // inhibit is released on sleep
  chk_sleep_float: assert property (@(posedge clock)
    disable iff (sys_rst) mode_q == CTW_SLEEP && !wakeEvt |-> !inhibitEn)
    else $error("inhibit driven in sleep");
  // wake drives inhibit next cycle
  chk_wake_inh: assert property (@(posedge clock)
    disable iff (sys_rst) wakeEvt |=> inhibitEn)
    else $error("inhibit not restored after wake");
  // drive enable, failure and power-on indications follow the mode
  chk_drive_en: assert property (@(posedge clock)
    disable iff (sys_rst) mode_q == CTW_NORMAL && !shortFail_q |=> highDriveEn)
    else $error("high driver not enabled in normal mode");
  chk_err_fail: assert property (@(posedge clock)
    disable iff (sys_rst) mode_d == CTW_NORMAL && wireFail_q |=> !errWake_n)
    else $error("line failure not shown on error output");
  chk_pon_show: assert property (@(posedge clock)
    disable iff (sys_rst) mode_d == CTW_PONSTBY && ponFlag_q |=> !errWake_n)
    else $error("power-on flag not shown in power-on standby");
endmodule

/* File: rtl/ctw_cfg.svh */
// timing constants and sizes for the transceiver mode and wake logic
`ifndef CTW_CFG_SVH
`define CTW_CFG_SVH
`define CTW_CLK_MHZ        50
`define CTW_WAKE_MIN_US    8
`define CTW_WAKE_MAX_US    38
`define CTW_BUS_WAKE_US    38
`define CTW_WAKE_CYC       ((`CTW_WAKE_MIN_US * `CTW_CLK_MHZ) + 1)
`define CTW_BUS_WAKE_CYC   ((`CTW_BUS_WAKE_US * `CTW_CLK_MHZ) + 1)
`define CTW_SLEEP_HOLD_US  5
`define CTW_SLEEP_HOLD_CYC (`CTW_SLEEP_HOLD_US * `CTW_CLK_MHZ)
`define CTW_PULSE_DIFF     4
`define CTW_FAULT_CYC      (1000 * `CTW_CLK_MHZ)
`define CTW_FIFO_DEPTH     4
`endif

/* File: rtl/ctw_pkg.sv */
// types shared by the transceiver mode and wake logic
package ctw_pkg;
  typedef enum logic [1:0] {
    CTW_SLEEP,
    CTW_GOSLEEP,
    CTW_PONSTBY,
    CTW_NORMAL
  } ctw_mode_t;
endpackage

/* File: rtl/ctw_fifo.sv */
// small valid/ready fifo for the transmit data path
module ctw_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // fill side
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  // drain side
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  // handshakes
  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;
  assign outData  = mem[rdPtr_q];

  // storage
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointers and fill count
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
      end
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: sim/ctw_bus_model.sv */
// behavioural two-wire bus seen through the block's comparators
module ctw_bus_model (
  // drivers from the block
  input  wire logic highDrive,
  input  wire logic lowDrive,
  input  wire logic highDriveEn,
  input  wire logic lowDriveEn,
  // faults commanded by the bench
  input  wire logic openHigh,
  input  wire logic forceDom,
  // comparator outputs to the block
  output logic      busHighDom,
  output logic      busLowDom,
  output logic      diffDom
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////////////////////////////////////////
  // an open high wire is pulled to recessive by its termination
  assign busHighDom = (highDriveEn & highDrive & ~openHigh) | forceDom;
  assign busLowDom  = (lowDriveEn & lowDrive) | forceDom;
  // receiver stays differential, so one live line still carries data
  assign diffDom    = busHighDom | busLowDom;
endmodule

/* File: sim/can_transceiver_mode_wake_ctrl_bench.sv */
// self-checking bench for the transceiver mode and wake logic
module can_transceiver_mode_wake_ctrl_bench
  import ctw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic      clock = 0, sys_rst = 1, txData = 1, txValid = 0;
  logic      standby_n = 1, enable = 0, logicSupplyOk = 1, localWake = 0;
  logic      openHigh = 0, forceDom = 0;
  logic      txReady, rxData, errWake_n, highDrive, lowDrive;
  logic      highDriveEn, lowDriveEn, inhibit, inhibitEn;
  logic      busHighDom, busLowDom, diffDom;
  ctw_mode_t mode;
  int        err_total = 0, check_count = 0, i;
  ////////////////////////////////////////////////////////////////////////////
  // clock, design and bus model
  always #10 clock = ~clock;
  ctw_ctrl dut_u (.clock(clock), .sys_rst(sys_rst), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData),
    .standby_n(standby_n), .enable(enable), .errWake_n(errWake_n),
    .logicSupplyOk(logicSupplyOk), .busHighDom(busHighDom),
    .busLowDom(busLowDom), .diffDom(diffDom), .highDrive(highDrive),
    .lowDrive(lowDrive), .highDriveEn(highDriveEn), .lowDriveEn(lowDriveEn),
    .localWake(localWake), .regulator_inhibit_out(inhibit),
    .inhibitEn(inhibitEn), .mode(mode));
  ctw_bus_model bus_u (.highDrive(highDrive), .lowDrive(lowDrive),
    .highDriveEn(highDriveEn), .lowDriveEn(lowDriveEn), .openHigh(openHigh),
    .forceDom(forceDom), .busHighDom(busHighDom), .busLowDom(busLowDom),
    .diffDom(diffDom));
  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask
  task automatic chk(input string name, input logic [1:0] e,
                     input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic goMode(input logic s, input logic e, input ctw_mode_t m);
    standby_n = s;
    enable = e;
    for (i = 0; i < 20 && mode !== m; i++) cyc(1);
    chk("mode", m, mode);
  endtask
  task automatic sendBit(input logic b);
    txData = b;
    txValid = 1'b1;
    for (i = 0; i < 20 && txReady !== 1'b1; i++) cyc(1);
    cyc(1);
    txValid = 1'b0;
    cyc(8);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic testReset();
    chk("mode", CTW_PONSTBY, mode);
    chk("inhibitEn", 1'b1, inhibitEn);
    chk("inhibit", 1'b1, inhibit);
    chk("errWake_n", 1'b0, errWake_n);
    chk("rxData", 1'b1, rxData);
    $display("test reset done");
  endtask
  task automatic testFifo();
    txData = 1'b0;
    txValid = 1'b1;
    for (int k = 0; k < 4; k++) begin
      chk("txReady", 1'b1, txReady);
      cyc(1);
    end
    chk("txReady full", 1'b0, txReady);
    cyc(3);
    chk("txReady held", 1'b0, txReady);
    txValid = 1'b0;
    goMode(1'b1, 1'b1, CTW_NORMAL);
    for (i = 0; i < 20 && txReady !== 1'b1; i++) cyc(1);
    chk("txReady drained", 1'b1, txReady);
    cyc(20);
    chk("errWake_n", 1'b1, errWake_n);
    goMode(1'b1, 1'b0, CTW_PONSTBY);
    cyc(2);
    chk("errWake_n pon cleared", 1'b1, errWake_n);
    goMode(1'b1, 1'b1, CTW_NORMAL);
    $display("test fifo done");
  endtask
  task automatic testTx();
    sendBit(1'b1);
    chk("drive rec", 2'b00, {highDrive, lowDrive});
    chk("rxData rec", 1'b1, rxData);
    sendBit(1'b0);
    chk("drive dom", 2'b11, {highDrive, lowDrive});
    chk("drive en", 2'b11, {highDriveEn, lowDriveEn});
    chk("rxData dom", 1'b0, rxData);
    sendBit(1'b1);
    chk("drive rec", 2'b00, {highDrive, lowDrive});
    chk("rxData rec", 1'b1, rxData);
    $display("test transmit done");
  endtask
  task automatic testFault();
    openHigh = 1'b1;
    for (int k = 0; k < 5; k++) begin
      sendBit(1'b0);
      sendBit(1'b1);
    end
    chk("errWake_n fault", 1'b0, errWake_n);
    openHigh = 1'b0;
    for (int k = 0; k < 5; k++) begin
      sendBit(1'b0);
      sendBit(1'b1);
    end
    chk("errWake_n clear", 1'b1, errWake_n);
    $display("test fault done");
  endtask
  task automatic testSupply();
    logicSupplyOk = 1'b0;
    cyc(10);
    chk("mode supply low", CTW_GOSLEEP, mode);
    logicSupplyOk = 1'b1;
    cyc(300);
    chk("mode supply back", CTW_NORMAL, mode);
    $display("test supply done");
  endtask
  task automatic toSleep();
    goMode(1'b1, 1'b1, CTW_NORMAL);
    goMode(1'b0, 1'b1, CTW_GOSLEEP);
    cyc(300);
    goMode(1'b0, 1'b0, CTW_SLEEP);
    cyc(5);
    chk("inhibitEn sleep", 1'b0, inhibitEn);
  endtask
  task automatic testLocalWake();
    toSleep();
    localWake = 1'b1;
    cyc(200);
    localWake = 1'b0;
    cyc(600);
    chk("inhibitEn short", 1'b0, inhibitEn);
    localWake = 1'b1;
    cyc(500);
    chk("inhibitEn wake", 1'b1, inhibitEn);
    chk("errWake_n wake", 1'b0, errWake_n);
    cyc(400);
    chk("inhibitEn stays", 1'b1, inhibitEn);
    chk("mode awake", CTW_GOSLEEP, mode);
    $display("test local wake done");
  endtask
  task automatic testBusWake();
    toSleep();
    forceDom = 1'b1;
    cyc(1000);
    forceDom = 1'b0;
    cyc(100);
    chk("inhibitEn short dom", 1'b0, inhibitEn);
    forceDom = 1'b1;
    cyc(2100);
    forceDom = 1'b0;
    chk("inhibitEn bus wake", 1'b1, inhibitEn);
    chk("errWake_n bus wake", 1'b0, errWake_n);
    $display("test bus wake done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    cyc(20);
    sys_rst = 1'b0;
    cyc(10);
    testReset();
    testFifo();
    testTx();
    testFault();
    testSupply();
    testLocalWake();
    testBusWake();
    summarize();
  end
  initial begin
    #1500000;
    err_total++;
    summarize();
  end
endmodule
